/* File: core/skip_sub_consts.svh */
`ifndef SKIP_SUB_CONSTS_SVH
`define SKIP_SUB_CONSTS_SVH

// ****************************************
// Widths
// ****************************************
`define DATA_W 8
`define ADDR_W 16
`define FLAG_W 6
`define BIT_SEL_W 3
`define APB_ADDR_W 12

// ****************************************
// Register offsets (byte addresses)
// ****************************************
`define OFS_ACC 12'h000
`define OFS_FLAGS 12'h004
`define OFS_CTRL 12'h008
`define OFS_STATUS 12'h00C

// ****************************************
// Flag bit positions
// ****************************************
`define FLG_CARRY 0
`define FLG_AUX 1
`define FLG_ZERO 2
`define FLG_OVF 3
`define FLG_SCMP 4
`define FLG_CZERO 5

// ****************************************
// Reset values and constants
// ****************************************
`define ACC_RST 8'h00
`define FLAGS_RST 6'h00
`define CTRL_RST 1'b1
`define CTRL_EN_BIT 0
`define BYTE_ZERO 8'h00
`define BYTE_ONE 8'h01
`define WORD_ZERO 32'h0000_0000
`define SKIP_CNT_W 16
`define SKIP_CNT_RST 16'h0000
`define SKIP_CNT_INC 16'h0001

`endif

/* File: core/skip_sub_pkg.sv */
`include "skip_sub_consts.svh"

package skip_sub_pkg;

  typedef enum logic [2:0] {
    op_inc_skip_zero_to_acc = 3'h0,
    op_skip_if_nonzero = 3'h1,
    op_skip_if_nonzero_bit = 3'h2,
    op_sub_to_acc = 3'h3,
    op_sub_to_mem = 3'h4,
    op_nibble_swap = 3'h5
  } op_t;

  typedef enum logic [2:0] {
    st_exec = 3'b001,
    st_squash = 3'b010,
    st_dummy = 3'b100
  } state_t;

  typedef struct packed {
    op_t op;
    logic [`ADDR_W-1:0] addr;
    logic [`BIT_SEL_W-1:0] bit_sel;
  } instr_t;

  typedef struct packed {
    logic [`ADDR_W-1:0] addr;
    logic [`DATA_W-1:0] data;
  } mem_wr_t;

  typedef struct packed {
    logic [`DATA_W-1:0] diff;
    logic [`FLAG_W-1:0] flags;
  } sub_res_t;

endpackage

/* File: core/sub_flag_calc.sv */
`timescale 1ns/10ps
`include "skip_sub_consts.svh"

module sub_flag_calc
(
  // Operands
  input wire logic [`DATA_W-1:0] minuend_i,
  input wire logic [`DATA_W-1:0] subtrahend_i,
  // Result
  output skip_sub_pkg::sub_res_t res_o
);
  import skip_sub_pkg::*;

  logic [`DATA_W:0] wide_diff;
  logic [4:0] nib_diff;
  logic [`DATA_W-1:0] diff;
  logic ovf;
  logic zero;

  assign wide_diff = {1'b0, minuend_i} - {1'b0, subtrahend_i};
  assign nib_diff = {1'b0, minuend_i[3:0]} - {1'b0, subtrahend_i[3:0]};
  assign diff = wide_diff[`DATA_W-1:0];
  assign zero = (diff == `BYTE_ZERO);
  assign ovf = (minuend_i[`DATA_W-1] ^ subtrahend_i[`DATA_W-1])
             & (minuend_i[`DATA_W-1] ^ diff[`DATA_W-1]);

  assign res_o.diff = diff;
  // Carry is the inverse of borrow: clear on negative result
  assign res_o.flags[`FLG_CARRY] = ~wide_diff[`DATA_W]; // RULE8
  assign res_o.flags[`FLG_AUX] = ~nib_diff[4];
  assign res_o.flags[`FLG_ZERO] = zero;
  assign res_o.flags[`FLG_OVF] = ovf;
  // Signed less-than seen through overflow
  assign res_o.flags[`FLG_SCMP] = ovf ^ diff[`DATA_W-1];
  // Single byte operation, so compare-zero tracks zero
  assign res_o.flags[`FLG_CZERO] = zero;

endmodule // sub_flag_calc

/* File: core/skip_and_subtract_execute.sv */
// Design decisions made here: the placing of the registers and the APB interface to the registers.
`timescale 1ns/10ps
`include "skip_sub_consts.svh"

// How it works
// RULE1: Increment-skip puts byte plus one in accumulator
// RULE2: Increment-skip skips when incremented value is zero
// RULE3: Taken skip adds squash and dummy cycles, three total
// RULE4: Bit form skips when selected bit one
// RULE5: Byte form skips when byte nonzero
// RULE6: Sub-to-acc stores accumulator minus byte
// RULE7: Sub-to-mem writes difference to memory
// RULE8: Carry cleared on borrow, else set
// RULE9: Subtracts update six flags, skips none
// RULE10: Nibble swap writes swapped byte back
// RULE11: Dummy cycles write nothing at all
module skip_and_subtract_execute
(
  // Clock and reset
  input wire logic mclk_i,
  input wire logic reset_i,
  // Instruction from decode
  input wire logic instr_valid_i,
  input wire skip_sub_pkg::instr_t instr_i,
  output logic instr_ready_o,
  output logic skip_taken_o,
  // Data memory
  output logic [`ADDR_W-1:0] mem_raddr_o,
  input wire logic [`DATA_W-1:0] mem_rdata_i,
  output logic mem_we_o,
  output skip_sub_pkg::mem_wr_t mem_wr_o,
  // Architectural state
  output logic [`DATA_W-1:0] accumulator_o,
  output logic [`FLAG_W-1:0] flags_o,
  // APB slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [`APB_ADDR_W-1:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o
);
  import skip_sub_pkg::*;

  // ****************************************
  // State
  // ****************************************
  state_t state_reg;
  state_t state_next;
  logic [`DATA_W-1:0] acc_reg;
  logic [`DATA_W-1:0] acc_next;
  logic [`FLAG_W-1:0] flags_reg;
  logic [`FLAG_W-1:0] flags_next;
  logic enable_reg;
  logic [`SKIP_CNT_W-1:0] skip_cnt_reg;
  logic mem_we_reg;
  mem_wr_t mem_wr_reg;
  logic skip_reg;

  // ****************************************
  // Decode and datapath
  // ****************************************
  wire logic issue;
  wire logic [`DATA_W-1:0] inc_val;
  wire logic [`DATA_W-1:0] swap_val;
  wire logic sel_bit;
  wire logic is_inc;
  wire logic is_nz;
  wire logic is_nzb;
  wire logic is_suba;
  wire logic is_subm;
  wire logic is_swap;
  wire logic skip_now;
  sub_res_t sub_res;

  sub_flag_calc u_flags
  (
    .minuend_i(acc_reg),
    .subtrahend_i(mem_rdata_i),
    .res_o(sub_res)
  );

  assign issue = instr_valid_i & instr_ready_o;
  assign is_inc = issue & (instr_i.op == op_inc_skip_zero_to_acc);
  assign is_nz = issue & (instr_i.op == op_skip_if_nonzero);
  assign is_nzb = issue & (instr_i.op == op_skip_if_nonzero_bit);
  assign is_suba = issue & (instr_i.op == op_sub_to_acc);
  assign is_subm = issue & (instr_i.op == op_sub_to_mem);
  assign is_swap = issue & (instr_i.op == op_nibble_swap);

  // Operand read is combinational so each instruction issues in one cycle; a taken skip takes three
  assign mem_raddr_o = instr_i.addr;
  assign inc_val = mem_rdata_i + `BYTE_ONE; // RULE1
  assign swap_val = {mem_rdata_i[3:0], mem_rdata_i[7:4]}; // RULE10
  assign sel_bit = mem_rdata_i[instr_i.bit_sel]; // RULE4

  assign skip_now = (is_inc & (inc_val == `BYTE_ZERO)) // RULE2
                  | (is_nz & (mem_rdata_i != `BYTE_ZERO)) // RULE5
                  | (is_nzb & sel_bit); // RULE4

  // Ready only in the execute state, so squashed slots do nothing
  assign instr_ready_o = enable_reg & (state_reg == st_exec); // RULE11

  // ****************************************
  // Sequencer
  // ****************************************
  always_comb
  begin
    state_next = state_reg;
    unique case (state_reg)
      st_exec:
      begin
        if (skip_now)
        begin
          state_next = st_squash; // RULE3
        end
      end
      st_squash:
      begin
        state_next = st_dummy; // RULE3
      end
      st_dummy:
      begin
        state_next = st_exec;
      end
      default:
      begin
        state_next = st_exec;
      end
    endcase
  end

  // ****************************************
  // APB decode
  // ****************************************
  wire logic apb_acc;
  wire logic apb_wr;
  wire logic hit_acc;
  wire logic hit_flags;
  wire logic hit_ctrl;
  wire logic hit_stat;
  wire logic hit_any;

  assign apb_acc = psel_i & penable_i;
  assign apb_wr = apb_acc & pwrite_i;
  assign hit_acc = (paddr_i == `OFS_ACC);
  assign hit_flags = (paddr_i == `OFS_FLAGS);
  assign hit_ctrl = (paddr_i == `OFS_CTRL);
  assign hit_stat = (paddr_i == `OFS_STATUS);
  assign hit_any = hit_acc | hit_flags | hit_ctrl | hit_stat;

  // Zero wait states; unmapped addresses and status writes report error
  assign pready_o = 1'b1;
  assign pslverr_o = apb_acc & (~hit_any | (pwrite_i & hit_stat));
  assign prdata_o = hit_acc ? {24'h00_0000, acc_reg}
                  : hit_flags ? {26'h000_0000, flags_reg}
                  : hit_ctrl ? {31'h0000_0000, enable_reg}
                  : hit_stat ? {13'h0000, state_reg, skip_cnt_reg}
                  : `WORD_ZERO;

  // ****************************************
  // Accumulator and flags
  // ****************************************
  // An instruction result outranks a software write in the same cycle
  always_comb
  begin
    acc_next = acc_reg;
    flags_next = flags_reg;
    if (apb_wr & hit_acc)
    begin
      acc_next = pwdata_i[`DATA_W-1:0];
    end
    if (apb_wr & hit_flags)
    begin
      flags_next = pwdata_i[`FLAG_W-1:0];
    end
    if (is_inc)
    begin
      acc_next = inc_val; // RULE1
    end
    if (is_suba)
    begin
      acc_next = sub_res.diff; // RULE6
    end
    if (is_suba | is_subm)
    begin
      flags_next = sub_res.flags; // RULE9
    end
  end

  always_ff @(posedge mclk_i)
  begin
    if (reset_i)
    begin
      state_reg <= st_exec;
      acc_reg <= `ACC_RST;
      flags_reg <= `FLAGS_RST;
      enable_reg <= `CTRL_RST;
      skip_cnt_reg <= `SKIP_CNT_RST;
      skip_reg <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      acc_reg <= acc_next;
      flags_reg <= flags_next;
      skip_reg <= skip_now;
      if (apb_wr & hit_ctrl)
      begin
        enable_reg <= pwdata_i[`CTRL_EN_BIT];
      end
      if (skip_now)
      begin
        skip_cnt_reg <= skip_cnt_reg + `SKIP_CNT_INC;
      end
    end
  end

  // ****************************************
  // Memory write port
  // ****************************************
  always_ff @(posedge mclk_i)
  begin
    if (reset_i)
    begin
      mem_we_reg <= 1'b0;
      mem_wr_reg <= '0;
    end
    else
    begin
      mem_we_reg <= is_subm | is_swap; // RULE7
      mem_wr_reg.addr <= instr_i.addr;
      mem_wr_reg.data <= is_subm ? sub_res.diff : swap_val; // RULE7
    end
  end

  assign mem_we_o = mem_we_reg;
  assign mem_wr_o = mem_wr_reg;
  assign skip_taken_o = skip_reg;
  assign accumulator_o = acc_reg;
  assign flags_o = flags_reg;

endmodule // skip_and_subtract_execute

/* File: verif/skip_sub_properties.sv */
`timescale 1ns/10ps
`include "skip_sub_consts.svh"

module skip_sub_properties
  import skip_sub_pkg::*;
(
  // Clock and reset
  input wire logic mclk_i,
  input wire logic reset_i,
  // Instruction and memory
  input wire logic instr_valid_i,
  input wire skip_sub_pkg::instr_t instr_i,
  input wire logic instr_ready_o,
  input wire logic skip_taken_o,
  input wire logic [`DATA_W-1:0] mem_rdata_i,
  input wire logic mem_we_o,
  input wire skip_sub_pkg::mem_wr_t mem_wr_o,
  // State
  input wire logic [`DATA_W-1:0] accumulator_o,
  input wire logic [`FLAG_W-1:0] flags_o
);
  default clocking
    @(posedge mclk_i);
  endclocking
  default disable iff (reset_i);
  wire logic go = instr_valid_i & instr_ready_o;
  wire logic hit = mem_rdata_i[instr_i.bit_sel];
  op_t op;
  assign op = instr_i.op;

  a_inc_value:
    assert property (go && op == op_inc_skip_zero_to_acc |=>
      accumulator_o == $past(mem_rdata_i) + 8'h01 && !mem_we_o)
      else $error("increment result wrong");
  a_inc_skip:
    assert property (go && op == op_inc_skip_zero_to_acc |=>
      skip_taken_o == ($past(mem_rdata_i) == 8'hFF))
      else $error("increment skip wrong");
  a_skip_gap:
    assert property (skip_taken_o |->
      !instr_ready_o ##1 !instr_ready_o ##1 instr_ready_o)
      else $error("skip gap wrong");
  a_bit_skip:
    assert property (go && op == op_skip_if_nonzero_bit |=>
      skip_taken_o == $past(hit))
      else $error("bit skip wrong");
  a_byte_skip:
    assert property (go && op == op_skip_if_nonzero |=>
      skip_taken_o == ($past(mem_rdata_i) != 8'h00))
      else $error("byte skip wrong");
  a_sub_mem:
    assert property (go && op == op_sub_to_mem |=> mem_we_o &&
      mem_wr_o.data == $past(accumulator_o) - $past(mem_rdata_i) &&
      $stable(accumulator_o)) else $error("memory subtract wrong");
  a_sub_carry:
    assert property (go && (op == op_sub_to_acc || op == op_sub_to_mem)
      |=> flags_o[`FLG_CARRY] == ($past(accumulator_o) >=
      $past(mem_rdata_i))) else $error("borrow flag wrong");
  a_skip_flags_kept:
    assert property (go && op <= op_skip_if_nonzero_bit |=>
      $stable(flags_o)) else $error("skip changed flags");
  a_dummy_quiet:
    assert property (skip_taken_o |-> ##1 (!mem_we_o &&
      $stable(accumulator_o) && $stable(flags_o)) [*2])
      else $error("write during skip gap");
  a_sub_acc:
    assert property (go && op == op_sub_to_acc |=>
      accumulator_o == $past(accumulator_o) - $past(mem_rdata_i))
      else $error("accumulator subtract wrong");
  a_swap_write:
    assert property (go && op == op_nibble_swap |=> mem_we_o &&
      mem_wr_o.data == {$past(mem_rdata_i[3:0]), $past(mem_rdata_i[7:4])}
      && $stable(flags_o)) else $error("nibble swap wrong");
endmodule // skip_sub_properties

bind skip_and_subtract_execute skip_sub_properties u_props (.mclk_i,
  .reset_i, .instr_valid_i, .instr_i, .instr_ready_o, .skip_taken_o,
  .mem_rdata_i, .mem_we_o, .mem_wr_o, .accumulator_o, .flags_o);

/* File: verif/skip_and_subtract_execute_tb.sv */
`timescale 1ns/10ps
`include "skip_sub_consts.svh"

module skip_and_subtract_execute_tb;
  import skip_sub_pkg::*;
  logic mclk_i = 0;
  logic reset_i = 1;
  logic instr_valid_i = 0;
  instr_t instr_i = '0;
  logic [7:0] mem_rdata_i = 0;
  logic psel_i = 0;
  logic penable_i = 0;
  logic pwrite_i = 0;
  logic [11:0] paddr_i = 0;
  logic [31:0] pwdata_i = 0;
  logic instr_ready_o, skip_taken_o, mem_we_o, pready_o, pslverr_o;
  mem_wr_t mem_wr_o;
  logic [7:0] accumulator_o;
  logic [5:0] flags_o;
  logic [31:0] prdata_o;
  logic [15:0] mem_raddr_o;
  int fails = 0;
  int n_compared = 0;
  int cyc = 0;

  skip_and_subtract_execute dut (.mclk_i, .reset_i, .instr_valid_i,
    .instr_i, .instr_ready_o, .skip_taken_o, .mem_raddr_o, .mem_rdata_i,
    .mem_we_o, .mem_wr_o, .accumulator_o, .flags_o, .psel_i, .penable_i,
    .pwrite_i, .paddr_i, .pwdata_i, .prdata_o, .pready_o, .pslverr_o);

  initial forever #10 mclk_i = ~mclk_i;
  // Whole run needs well under a thousand cycles
  always @(posedge mclk_i)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      fails++;
      test_done();
    end
  end

  task automatic test_done;
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic ck(logic [31:0] g, logic [31:0] e, string m);
    n_compared++;
    if (g !== e)
    begin
      fails++;
      $display("MISMATCH at %0t: %s got %h want %h", $time, m, g, e);
    end
  endtask

  task automatic apb(logic w, logic [11:0] a, logic [31:0] wd,
    output logic [31:0] rd, output logic er);
    @(posedge mclk_i);
    psel_i <= 1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= wd;
    @(posedge mclk_i);
    penable_i <= 1;
    do @(posedge mclk_i); while (pready_o !== 1'b1);
    rd = prdata_o;
    er = pslverr_o;
    psel_i <= 0;
    penable_i <= 0;
  endtask

  // Expected effects worked out here; a taken skip keeps a stale
  // request offered through the gap to prove it is refused
  task automatic run(op_t op, logic [2:0] b, logic [7:0] d);
    logic [7:0] a0, ea, ed;
    logic [5:0] f0, ef;
    logic sk, ew;
    int sd;
    @(posedge mclk_i);
    a0 = accumulator_o;
    f0 = flags_o;
    // Flags worked out from signed and unsigned compares of the operands
    sd = $signed(a0) - $signed(d);
    ef = {a0 == d, sd < 0, sd > 127 || sd < -128, a0 == d,
      a0[3:0] >= d[3:0], a0 >= d};
    sk = op == op_inc_skip_zero_to_acc ? d == 8'hFF :
      op == op_skip_if_nonzero ? d != 8'h00 :
      op == op_skip_if_nonzero_bit ? d[b] : 1'b0;
    ea = op == op_inc_skip_zero_to_acc ? d + 8'h01 :
      op == op_sub_to_acc ? a0 - d : a0;
    ew = op == op_sub_to_mem || op == op_nibble_swap;
    ed = op == op_sub_to_mem ? a0 - d : {d[3:0], d[7:4]};
    instr_valid_i <= 1;
    instr_i <= '{op: op, addr: 16'h0123, bit_sel: b};
    mem_rdata_i <= d;
    do @(posedge mclk_i); while (instr_ready_o !== 1'b1);
    instr_valid_i <= sk;
    instr_i.op <= op_sub_to_mem;
    #1;
    ck(accumulator_o, ea, "acc");
    ck(skip_taken_o, sk, "skip");
    ck(mem_we_o, ew, "write");
    if (ew) ck(mem_wr_o, {16'h0123, ed}, "wdata");
    ck(mem_raddr_o, 16'h0123, "raddr");
    if (op == op_sub_to_acc || op == op_sub_to_mem)
      ck(flags_o, ef, "sub flags");
    else
      ck(flags_o, f0, "flags");
    if (sk)
    begin
      ck(instr_ready_o, 0, "squash");
      @(posedge mclk_i);
      #1;
      ck(instr_ready_o, 0, "dummy");
      @(posedge mclk_i);
      instr_valid_i <= 0;
      #1;
      ck(instr_ready_o, 1, "resume");
      ck({mem_we_o, accumulator_o, flags_o}, {1'b0, ea, f0}, "gap");
    end
  endtask

  task automatic t_regs;
    logic [31:0] r;
    logic e;
    apb(0, `OFS_CTRL, 0, r, e);
    ck(r[0], 1, "enable at reset");
    apb(0, `OFS_STATUS, 0, r, e);
    ck(r, 32'h0001_0000, "status at reset");
    apb(0, 12'h010, 0, r, e);
    ck(e, 1, "unmapped error");
    ck(r, 32'h0000_0000, "unmapped data");
    apb(1, `OFS_ACC, 32'h0000_005A, r, e);
    apb(0, `OFS_ACC, 0, r, e);
    ck(r, 32'h0000_005A, "acc readback");
    ck(e, 0, "acc no error");
  endtask

  task automatic t_inc;
    run(op_inc_skip_zero_to_acc, 0, 8'h41);
    run(op_inc_skip_zero_to_acc, 0, 8'hFF);
    run(op_inc_skip_zero_to_acc, 0, 8'h7F);
  endtask

  task automatic t_skip;
    run(op_skip_if_nonzero, 0, 8'h00);
    run(op_skip_if_nonzero, 0, 8'h80);
    for (int i = 0; i < 8; i++)
    begin
      run(op_skip_if_nonzero_bit, i[2:0], 8'h01 << i);
      run(op_skip_if_nonzero_bit, i[2:0], ~(8'h01 << i));
    end
  endtask

  task automatic t_sub;
    logic [31:0] r;
    logic e;
    apb(1, `OFS_ACC, 32'h0000_0005, r, e);
    run(op_sub_to_acc, 0, 8'h03);
    ck(flags_o[`FLG_CARRY], 1, "no borrow");
    run(op_sub_to_acc, 0, 8'h05);
    ck(flags_o[`FLG_CARRY], 0, "borrow");
    run(op_sub_to_mem, 0, 8'h10);
    ck(flags_o[`FLG_CARRY], 1, "mem no borrow");
    run(op_sub_to_acc, 0, 8'hFD);
    ck(flags_o[`FLG_CARRY], 1, "equal");
    ck(flags_o[`FLG_ZERO], 1, "zero");
    apb(1, `OFS_ACC, 32'h0000_0080, r, e);
    run(op_sub_to_acc, 0, 8'h01);
    ck(flags_o[`FLG_OVF], 1, "overflow");
    run(op_nibble_swap, 0, 8'h3C);
  endtask

  // Ten skips were taken by the earlier scenarios; status counts them
  task automatic t_enable;
    logic [31:0] r;
    logic e;
    logic [7:0] a1;
    apb(0, `OFS_STATUS, 0, r, e);
    ck(r, 32'h0001_000A, "skip count");
    apb(1, `OFS_STATUS, 0, r, e);
    ck(e, 1, "status write");
    apb(1, `OFS_FLAGS, 32'h0000_002A, r, e);
    apb(0, `OFS_FLAGS, 0, r, e);
    ck(r, 32'h0000_002A, "flags readback");
    ck(flags_o, 6'h2A, "flags out");
    apb(1, `OFS_CTRL, 0, r, e);
    a1 = accumulator_o;
    instr_valid_i <= 1;
    instr_i <= '{op: op_inc_skip_zero_to_acc, addr: 16'h0123, bit_sel: 0};
    mem_rdata_i <= 8'h10;
    repeat (3) @(posedge mclk_i);
    instr_valid_i <= 0;
    #1;
    ck({instr_ready_o, accumulator_o}, {1'b0, a1}, "disabled");
    apb(0, `OFS_CTRL, 0, r, e);
    ck(r, 32'h0000_0000, "enable off");
    apb(1, `OFS_CTRL, 1, r, e);
  endtask

  task automatic t_reset;
    @(posedge mclk_i);
    reset_i <= 1;
    repeat (2) @(posedge mclk_i);
    reset_i <= 0;
    #1;
    ck({instr_ready_o, skip_taken_o, mem_we_o, accumulator_o, flags_o},
      {3'b100, 8'h00, 6'h00}, "after reset");
  endtask

  initial
  begin
    repeat (16) @(posedge mclk_i);
    reset_i <= 0;
    t_regs();
    t_inc();
    t_skip();
    t_sub();
    t_enable();
    t_reset();
    test_done();
  end
endmodule // skip_and_subtract_execute_tb
